// ### spm_pkg.sv
// Purpose: Constants and types shared by the standby and power mode control block
// Assumes: One 100 MHz clock; registers reached over a plain strobe port
// Notes: Mode codes follow the mode control register encoding
package spm_pkg;
    localparam int SPM_CLK_MHZ = 100;
    localparam int SPM_SLOW_CLOCK_RATE_KHZ = 32;
    localparam int SPM_SLOW_DIV = (SPM_CLK_MHZ * 1000) / (2 * SPM_SLOW_CLOCK_RATE_KHZ);
    localparam int SPM_OSC_WAIT_US = 6700;
    localparam int SPM_OSC_WAIT_CYC = SPM_OSC_WAIT_US * SPM_CLK_MHZ;
    localparam logic [3:0] SPM_ADDR_MODE = 4'h0;
    localparam logic [3:0] SPM_ADDR_MEMCTL = 4'h1;
    localparam logic [3:0] SPM_ADDR_IRQ_REQ = 4'h2;
    localparam logic [3:0] SPM_ADDR_IRQ_EN = 4'h3;
    localparam logic [3:0] SPM_ADDR_STATUS = 4'h4;
    localparam logic [3:0] SPM_MODE_NORMAL = 4'h0;
    localparam logic [3:0] SPM_MODE_IDLE = 4'h1;
    localparam logic [3:0] SPM_MODE_SLOW = 4'h3;
    localparam logic [3:0] SPM_MODE_HALT = 4'h4;
    localparam logic [3:0] SPM_MODE_STOP = 4'h8;
    localparam int SPM_MEMCTL_PERMIT_BIT = 2;
    localparam logic [7:0] SPM_MEMCTL_RST = 8'h00;
    typedef enum logic [3:0] {
        SPM_ST_RESET_WAIT = 4'b0000,
        SPM_ST_NORMAL = 4'b0001,
        SPM_ST_SLOW = 4'b0010,
        SPM_ST_IDLE = 4'b0011,
        SPM_ST_FAST_HALT = 4'b0100,
        SPM_ST_SLOW_HALT = 4'b0101,
        SPM_ST_FAST_STOP = 4'b0110,
        SPM_ST_SLOW_STOP = 4'b0111,
        SPM_ST_STOP_WAKE = 4'b1000
    } spm_state_t;
endpackage : spm_pkg

// ### spm_wait_timer.sv
// Purpose: Oscillator stabilisation wait counter
// Assumes: Start is a one-cycle pulse
// Notes: Done pulses once when the count expires
`timescale 1ns/100ps
module spm_wait_timer #(
    parameter int WAIT_CYC = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    output logic done
);
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } spm_wt_t;
    spm_wt_t s_r;
    spm_wt_t s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start) begin
            s_nxt.cnt = 32'(WAIT_CYC);
            s_nxt.busy = 1'b1;
        end else if (s_r.busy) begin
            if (s_r.cnt <= 32'h00000001) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.cnt = 32'h00000000;
            end else begin
                s_nxt.cnt = s_r.cnt - 32'h00000001;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign done = s_r.done;
endmodule : spm_wait_timer

// ### spm_slow_clkgen.sv
// Purpose: Derives the 32 kHz low-frequency clock as a divided square wave
// Assumes: Enable low stops the divider
// Notes: Output stays low while stopped
`timescale 1ns/100ps
module spm_slow_clkgen #(
    parameter int DIV = 1562
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    output logic slow_clk
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tog;
    } spm_sc_t;
    spm_sc_t s_r;
    spm_sc_t s_nxt;
    always_comb begin
        s_nxt = s_r;
        if (!en) begin
            s_nxt = '0;
        end else if (s_r.cnt >= 16'(DIV - 1)) begin
            s_nxt.cnt = 16'h0000;
            s_nxt.tog = ~s_r.tog;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign slow_clk = s_r.tog;
endmodule : spm_slow_clkgen

// ### spm_standby_ctrl.sv
// Purpose: Operating and standby mode control with oscillator gating and clock select
// Assumes: Register port with one-cycle strobes; interrupt sources are level inputs
// Notes: Every output except SLOW_CLK comes from the state register; SLOW_CLK comes from its own flop
`timescale 1ns/100ps
module spm_standby_ctrl
    import spm_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter int OSC_WAIT_CYC = SPM_OSC_WAIT_CYC
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic [NUM_IRQ-1:0] IRQ_SRC,
    input wire logic WDT_EN,
    output logic CPU_RUN,
    output logic FAST_OSC_EN,
    output logic SLOW_OSC_EN,
    output logic SYSCLK_SEL_SLOW,
    output logic SLOW_CLK,
    output logic WDT_RUN,
    output logic WAKE_IRQ
);
    typedef struct packed {
        spm_state_t st;
        logic [7:0] memctl;
        logic [NUM_IRQ-1:0] req;
        logic [NUM_IRQ-1:0] en;
        logic [7:0] rdata;
        logic cpu_run;
        logic fast_en;
        logic slow_en;
        logic sel_slow;
        logic wdt_run;
        logic wake;
        logic wait_start;
    } spm_top_t;

    spm_top_t s_r;
    spm_top_t s_nxt;
    logic wait_done;
    logic slow_clk_int;
    logic wake_any;

    function automatic logic [7:0] spm_pad(input logic [NUM_IRQ-1:0] v);
        logic [7:0] o;
        o = '0;
        for (int i = 0; i < NUM_IRQ && i < 8; i++) begin
            o[i] = v[i];
        end
        return o;
    endfunction : spm_pad

    function automatic logic [3:0] spm_mode_code(input spm_state_t st);
        logic [3:0] c;
        c = SPM_MODE_NORMAL;
        case (st)
            SPM_ST_SLOW: c = SPM_MODE_SLOW;
            SPM_ST_IDLE: c = SPM_MODE_IDLE;
            SPM_ST_FAST_HALT, SPM_ST_SLOW_HALT: c = SPM_MODE_HALT;
            SPM_ST_FAST_STOP, SPM_ST_SLOW_STOP, SPM_ST_STOP_WAKE: c = SPM_MODE_STOP;
            default: c = SPM_MODE_NORMAL;
        endcase
        return c;
    endfunction : spm_mode_code

    spm_wait_timer #(
        .WAIT_CYC(OSC_WAIT_CYC)
    ) spm_wait_timer_i (
        .clk(CLOCK),
        .rst_b(RST_B),
        .start(s_r.wait_start),
        .done(wait_done)
    );

    spm_slow_clkgen #(
        .DIV(SPM_SLOW_DIV)
    ) spm_slow_clkgen_i (
        .clk(CLOCK),
        .rst_b(RST_B),
        .en(s_r.slow_en),
        .slow_clk(slow_clk_int)
    );

    assign wake_any = |(s_r.req & s_r.en);

    always_comb begin
        logic mode_wr;
        logic [3:0] mcode;
        logic [NUM_IRQ-1:0] clr;
        mode_wr = WR && (ADDR == SPM_ADDR_MODE);
        mcode = WDATA[3:0];
        clr = '0;
        s_nxt = s_r;
        s_nxt.wait_start = 1'b0;
        s_nxt.rdata = 8'h00;
        if (WR && ADDR == SPM_ADDR_MEMCTL) begin
            s_nxt.memctl = WDATA;
        end else if (WR && ADDR == SPM_ADDR_IRQ_EN) begin
            s_nxt.en = WDATA[NUM_IRQ-1:0];
        end else if (WR && ADDR == SPM_ADDR_IRQ_REQ) begin
            if (s_r.memctl[SPM_MEMCTL_PERMIT_BIT]) begin
                clr = ~WDATA[NUM_IRQ-1:0];
            end
        end
        // Set wins over clear
        s_nxt.req = (s_r.req & ~clr) | IRQ_SRC;
        if (RD) begin
            if (ADDR == SPM_ADDR_MODE) begin
                s_nxt.rdata = {4'h0, spm_mode_code(s_r.st)};
            end else if (ADDR == SPM_ADDR_MEMCTL) begin
                s_nxt.rdata = s_r.memctl;
            end else if (ADDR == SPM_ADDR_IRQ_REQ) begin
                s_nxt.rdata = spm_pad(s_r.req);
            end else if (ADDR == SPM_ADDR_IRQ_EN) begin
                s_nxt.rdata = spm_pad(s_r.en);
            end else if (ADDR == SPM_ADDR_STATUS) begin
                s_nxt.rdata = {3'h0, s_r.sel_slow, s_r.fast_en, s_r.slow_en, s_r.cpu_run,
                    wake_any};
            end else begin
                s_nxt.rdata = 8'h00;
            end
        end
        case (s_r.st)
            SPM_ST_RESET_WAIT: begin
                if (wait_done) begin
                    s_nxt.st = SPM_ST_NORMAL;
                end
            end
            SPM_ST_NORMAL: begin
                if (mode_wr) begin
                    if (mcode == SPM_MODE_SLOW) begin
                        s_nxt.st = SPM_ST_SLOW;
                    end else if (mcode == SPM_MODE_HALT) begin
                        s_nxt.st = SPM_ST_FAST_HALT;
                    end else if (mcode == SPM_MODE_STOP) begin
                        s_nxt.st = SPM_ST_FAST_STOP;
                    end
                end
            end
            SPM_ST_SLOW: begin
                if (mode_wr) begin
                    if (mcode == SPM_MODE_IDLE) begin
                        s_nxt.st = SPM_ST_IDLE;
                    end else if (mcode == SPM_MODE_HALT) begin
                        s_nxt.st = SPM_ST_SLOW_HALT;
                    end else if (mcode == SPM_MODE_STOP) begin
                        s_nxt.st = SPM_ST_SLOW_STOP;
                    end
                end
            end
            SPM_ST_IDLE: begin
                if (mode_wr) begin
                    if (mcode == SPM_MODE_NORMAL) begin
                        s_nxt.st = SPM_ST_NORMAL;
                    end else if (mcode == SPM_MODE_SLOW) begin
                        s_nxt.st = SPM_ST_SLOW;
                    end
                end
            end
            SPM_ST_FAST_HALT: begin
                if (wake_any) begin
                    s_nxt.st = SPM_ST_NORMAL;
                end
            end
            SPM_ST_SLOW_HALT: begin
                if (wake_any) begin
                    s_nxt.st = SPM_ST_SLOW;
                end
            end
            SPM_ST_FAST_STOP: begin
                if (wake_any) begin
                    s_nxt.st = SPM_ST_STOP_WAKE;
                    s_nxt.sel_slow = 1'b0;
                    s_nxt.wait_start = 1'b1;
                end
            end
            SPM_ST_SLOW_STOP: begin
                if (wake_any) begin
                    s_nxt.st = SPM_ST_STOP_WAKE;
                    s_nxt.sel_slow = 1'b1;
                    s_nxt.wait_start = 1'b1;
                end
            end
            SPM_ST_STOP_WAKE: begin
                if (wait_done) begin
                    s_nxt.st = s_r.sel_slow ? SPM_ST_SLOW : SPM_ST_NORMAL;
                end
            end
            default: begin
                s_nxt.st = SPM_ST_RESET_WAIT;
            end
        endcase
        // Outputs decoded from the next state
        case (s_nxt.st)
            SPM_ST_NORMAL: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'hE;
            end
            SPM_ST_SLOW: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'hB;
            end
            SPM_ST_IDLE: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'hF;
            end
            SPM_ST_FAST_HALT: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'h6;
            end
            SPM_ST_SLOW_HALT: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'h3;
            end
            SPM_ST_FAST_STOP: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'h0;
            end
            SPM_ST_SLOW_STOP: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'h1;
            end
            SPM_ST_STOP_WAKE: begin
                s_nxt.cpu_run = 1'b0;
                s_nxt.fast_en = 1'b1;
                s_nxt.slow_en = 1'b1;
            end
            default: begin
                {s_nxt.cpu_run, s_nxt.fast_en, s_nxt.slow_en, s_nxt.sel_slow} = 4'h6;
            end
        endcase
        s_nxt.wdt_run = WDT_EN && s_nxt.cpu_run;
        s_nxt.wake = wake_any;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s_r <= '0;
            s_r.st <= SPM_ST_RESET_WAIT;
            s_r.memctl <= SPM_MEMCTL_RST;
            s_r.fast_en <= 1'b1;
            s_r.slow_en <= 1'b1;
            s_r.wait_start <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    logic slow_clk_r;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            slow_clk_r <= 1'b0;
        end else begin
            slow_clk_r <= slow_clk_int;
        end
    end

    assign RDATA = s_r.rdata;
    assign CPU_RUN = s_r.cpu_run;
    assign FAST_OSC_EN = s_r.fast_en;
    assign SLOW_OSC_EN = s_r.slow_en;
    assign SYSCLK_SEL_SLOW = s_r.sel_slow;
    assign SLOW_CLK = slow_clk_r;
    assign WDT_RUN = s_r.wdt_run;
    assign WAKE_IRQ = s_r.wake;
endmodule : spm_standby_ctrl

// ### spm_standby_ctrl_assertions.sv
// Purpose: Port-level checks of mode, oscillator and clock select behaviour
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/100ps
module spm_ctrl_assertions
    import spm_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter int OSC_WAIT_CYC = 20
) (
    input logic CLOCK,
    input logic RST_B,
    input logic [3:0] ADDR,
    input logic [7:0] WDATA,
    input logic WR,
    input logic RD,
    input logic [7:0] RDATA,
    input logic [NUM_IRQ-1:0] IRQ_SRC,
    input logic WDT_EN,
    input logic CPU_RUN,
    input logic FAST_OSC_EN,
    input logic SLOW_OSC_EN,
    input logic SYSCLK_SEL_SLOW,
    input logic SLOW_CLK,
    input logic WDT_RUN,
    input logic WAKE_IRQ
);
    localparam int WAIT_MAX = OSC_WAIT_CYC + 6;
    logic stopped_r;
    logic sel_r;
    logic mode_wr;
    assign mode_wr = WR && ADDR == SPM_ADDR_MODE;
    // Remembers a stop entry and the clock selection of the last running cycle
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            stopped_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            stopped_r <= !CPU_RUN && (stopped_r || !SLOW_OSC_EN);
            if (CPU_RUN) begin
                sel_r <= SYSCLK_SEL_SLOW;
            end
        end
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    halt_entry_a: assert property (mode_wr && WDATA == {4'h0, SPM_MODE_HALT} && CPU_RUN
        && !SYSCLK_SEL_SLOW && !WAKE_IRQ |-> ##[1:2] (!CPU_RUN && FAST_OSC_EN && SLOW_OSC_EN))
        else $error("fast halt entry wrong");
    stop_entry_a: assert property (mode_wr && WDATA == {4'h0, SPM_MODE_STOP} && CPU_RUN
        && !WAKE_IRQ |-> ##[1:2] (!CPU_RUN && !FAST_OSC_EN && !SLOW_OSC_EN))
        else $error("stop entry wrong");
    stop_hold_a: assert property ((!CPU_RUN && !FAST_OSC_EN && !SLOW_OSC_EN && !WAKE_IRQ)
        ##1 !WAKE_IRQ
        |-> !FAST_OSC_EN && !SLOW_OSC_EN) else $error("stop left without wake");
    stop_wait_a: assert property ($rose(SLOW_OSC_EN) |-> !CPU_RUN [*8]
        ##[1:WAIT_MAX] CPU_RUN) else $error("stop wake wait wrong");
    halt_wake_a: assert property ($rose(WAKE_IRQ) && !stopped_r |-> CPU_RUN)
        else $error("halt wake late");
    restore_sel_a: assert property ($rose(CPU_RUN) |-> SYSCLK_SEL_SLOW == sel_r)
        else $error("clock selection not restored");
    slow_sel_a: assert property (CPU_RUN && !FAST_OSC_EN |-> SYSCLK_SEL_SLOW && SLOW_OSC_EN)
        else $error("running without fast osc not on slow clock");
    fast_sel_a: assert property (CPU_RUN && !SYSCLK_SEL_SLOW |-> FAST_OSC_EN)
        else $error("fast clock selected with fast osc off");
    run_fall_a: assert property ($fell(CPU_RUN) |-> $past(mode_wr))
        else $error("standby entered without write");
    wdt_resume_a: assert property (CPU_RUN && $past(CPU_RUN) && WDT_EN && $past(WDT_EN)
        |-> WDT_RUN) else $error("watchdog not running");
    slow_off_a: assert property (!SLOW_OSC_EN [*3] |-> !SLOW_CLK)
        else $error("slow clock toggles while off");
    cover property ($rose(CPU_RUN) && !stopped_r && SLOW_OSC_EN);
    cover property ($rose(SLOW_OSC_EN));
    cover property (CPU_RUN && !FAST_OSC_EN);
endmodule : spm_ctrl_assertions
bind spm_standby_ctrl spm_ctrl_assertions #(.NUM_IRQ(NUM_IRQ), .OSC_WAIT_CYC(OSC_WAIT_CYC))
    spm_ctrl_assertions_i (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_SRC(IRQ_SRC), .WDT_EN(WDT_EN),
    .CPU_RUN(CPU_RUN), .FAST_OSC_EN(FAST_OSC_EN), .SLOW_OSC_EN(SLOW_OSC_EN),
    .SYSCLK_SEL_SLOW(SYSCLK_SEL_SLOW), .SLOW_CLK(SLOW_CLK), .WDT_RUN(WDT_RUN),
    .WAKE_IRQ(WAKE_IRQ));

// ### test_standby_power_mode_control.sv
// Purpose: Self-checking bench for the standby and power mode control block
// Assumes: Short stabilisation wait of WAIT cycles
// Notes: Status outputs packed as sel, fast, slow, run
`timescale 1ns/100ps
module test_standby_power_mode_control import spm_pkg::*;;
    localparam int WAIT = 20;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [7:0] IRQ_SRC = 8'h00;
    logic WDT_EN = 1'b1;
    logic [7:0] RDATA;
    logic CPU_RUN, FAST_OSC_EN, SLOW_OSC_EN, SYSCLK_SEL_SLOW, SLOW_CLK, WDT_RUN, WAKE_IRQ;
    int fail_count = 0;
    int comparisons = 0;
    always #5 CLOCK = ~CLOCK;
    spm_standby_ctrl #(.NUM_IRQ(8), .OSC_WAIT_CYC(WAIT)) spm_standby_ctrl_i (
        .CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IRQ_SRC(IRQ_SRC), .WDT_EN(WDT_EN), .CPU_RUN(CPU_RUN),
        .FAST_OSC_EN(FAST_OSC_EN), .SLOW_OSC_EN(SLOW_OSC_EN),
        .SYSCLK_SEL_SLOW(SYSCLK_SEL_SLOW), .SLOW_CLK(SLOW_CLK), .WDT_RUN(WDT_RUN),
        .WAKE_IRQ(WAKE_IRQ));
    task summarize;
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task st(input logic [3:0] e);
        @(negedge CLOCK);
        chk({4'h0, SYSCLK_SEL_SLOW, FAST_OSC_EN, SLOW_OSC_EN, CPU_RUN}, {4'h0, e});
    endtask : st
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(negedge CLOCK);
        chk(RDATA, e);
    endtask : rd
    task wait_run(output int n);
        n = 0;
        while (CPU_RUN !== 1'b1) begin
            @(negedge CLOCK);
            n++;
            if (n > 200) begin
                fail_count++;
                summarize();
            end
        end
    endtask : wait_run
    task wake(output int n);
        @(posedge CLOCK);
        IRQ_SRC <= 8'h01;
        wait_run(n);
        chk({7'h0, WAKE_IRQ}, 8'h01);
        @(posedge CLOCK);
        IRQ_SRC <= 8'h00;
        wr(SPM_ADDR_IRQ_REQ, 8'h00);
    endtask : wake
    task t_reset;
        int n;
        st(4'b0110);
        repeat (3) @(posedge CLOCK);
        RST_B <= 1'b1;
        repeat (WAIT - 4) @(negedge CLOCK);
        chk({7'h0, CPU_RUN}, 8'h00);
        wait_run(n);
        st(4'b0111);
        rd(SPM_ADDR_STATUS, 8'h0E);
        rd(SPM_ADDR_MEMCTL, SPM_MEMCTL_RST);
        rd(4'hF, 8'h00);
    endtask : t_reset
    task t_flags;
        @(posedge CLOCK);
        IRQ_SRC <= 8'h02;
        @(posedge CLOCK);
        IRQ_SRC <= 8'h00;
        wr(SPM_ADDR_IRQ_REQ, 8'h00);
        rd(SPM_ADDR_IRQ_REQ, 8'h02);
        wr(SPM_ADDR_MEMCTL, 8'h04);
        wr(SPM_ADDR_IRQ_REQ, 8'h00);
        rd(SPM_ADDR_IRQ_REQ, 8'h00);
        wr(SPM_ADDR_IRQ_EN, 8'h01);
    endtask : t_flags
    task t_halt(input logic [3:0] in_halt, input logic [3:0] after);
        int n;
        wr(SPM_ADDR_MODE, {4'h0, SPM_MODE_HALT});
        repeat (3) @(posedge CLOCK);
        repeat (6) st(in_halt);
        chk({7'h0, WDT_RUN}, 8'h00);
        wake(n);
        chk({7'h0, n <= 4}, 8'h01);
        st(after);
        chk({7'h0, WDT_RUN}, 8'h01);
    endtask : t_halt
    task t_stop(input logic [3:0] after);
        int n;
        wr(SPM_ADDR_MODE, {4'h0, SPM_MODE_STOP});
        repeat (3) @(posedge CLOCK);
        repeat (6) begin
            @(negedge CLOCK);
            chk({5'h0, FAST_OSC_EN, SLOW_OSC_EN, CPU_RUN}, 8'h00);
        end
        wake(n);
        chk({7'h0, n > WAIT}, 8'h01);
        st(after);
    endtask : t_stop
    task t_slow;
        int n;
        wr(SPM_ADDR_MODE, {4'h0, SPM_MODE_SLOW});
        repeat (2) st(4'b1011);
        n = 0;
        while (SLOW_CLK !== 1'b0 && n < 4000) begin
            @(negedge CLOCK);
            n++;
        end
        while (SLOW_CLK !== 1'b1 && n < 8000) begin
            @(negedge CLOCK);
            n++;
        end
        if (n >= 8000) begin
            fail_count++;
            summarize();
        end
        n = 0;
        while (SLOW_CLK === 1'b1 && n < 4000) begin
            @(negedge CLOCK);
            n++;
        end
        if (n >= 4000) begin
            fail_count++;
            summarize();
        end
        chk({7'h0, n == SPM_SLOW_DIV}, 8'h01);
        wr(SPM_ADDR_MODE, {4'h0, SPM_MODE_NORMAL});
        st(4'b1011);
        rd(SPM_ADDR_MODE, {4'h0, SPM_MODE_SLOW});
    endtask : t_slow
    task t_idle;
        wr(SPM_ADDR_MODE, {4'h0, SPM_MODE_IDLE});
        repeat (2) st(4'b1111);
        wr(SPM_ADDR_MODE, {4'h0, SPM_MODE_NORMAL});
        repeat (2) st(4'b0111);
        @(posedge CLOCK);
        WDT_EN <= 1'b0;
        repeat (2) @(negedge CLOCK);
        chk({7'h0, WDT_RUN}, 8'h00);
        @(posedge CLOCK);
        WDT_EN <= 1'b1;
    endtask : t_idle
    initial begin
        t_reset();
        t_flags();
        t_halt(4'b0110, 4'b0111);
        t_slow();
        t_halt(4'b1010, 4'b1011);
        t_stop(4'b1011);
        t_idle();
        t_stop(4'b0111);
        summarize();
    end
endmodule : test_standby_power_mode_control
